// file: xirq_cfg.svh
// Register offsets, field positions, reset values and defaults for the external request block
`ifndef XIRQ_CFG_SVH
`define XIRQ_CFG_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define XIRQ_ADDR_TIMER_CTRL 8'h88
`define XIRQ_ADDR_PRIO_HIGH 8'hbb
`define XIRQ_ADDR_PRIO_LOW 8'hbc
`define XIRQ_ADDR_EXTRA_CTRL 8'hc0

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define XIRQ_TC_TRIG0 0
`define XIRQ_TC_FLAG0 1
`define XIRQ_TC_TRIG1 2
`define XIRQ_TC_FLAG1 3
`define XIRQ_XC_TRIG2 0
`define XIRQ_XC_FLAG2 1
`define XIRQ_XC_EN2 2
`define XIRQ_XC_PLO2 3
`define XIRQ_XC_TRIG3 4
`define XIRQ_XC_FLAG3 5
`define XIRQ_XC_EN3 6
`define XIRQ_XC_PLO3 7
`define XIRQ_EP_SPI 0
`define XIRQ_EP_WAKE 1
`define XIRQ_EP_BOD 2

// ----------------------------------------------------------------
// Reset values and defaults
// ----------------------------------------------------------------
`define XIRQ_RST_BYTE 8'h00
`define XIRQ_RST_PIN 4'hf
`define XIRQ_MC_CLKS_DEF 12
`define XIRQ_NUM_SRC 7

`endif

// file: xirq_pkg.sv
// Types shared by the external request block
package xirq_pkg;

    typedef logic [1:0] xirq_lvl_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic we;
        logic re;
    } xirq_bus_t;

    typedef struct packed {
        logic valid;
        logic [2:0] idx;
        xirq_lvl_t lvl;
    } xirq_grant_t;

    typedef struct packed {
        logic [3:0] sync1;
        logic [3:0] sync2;
        logic [3:0] samp;
        logic [7:0] mc_cnt;
        logic [3:0] trig;
        logic [3:0] flag;
        logic [1:0] en23;
        logic [1:0] plo23;
        logic [2:0] ep_hi;
        logic [2:0] ep_lo;
        logic [7:0] rdata;
        logic [3:0] pend;
        xirq_lvl_t lvl2;
        xirq_lvl_t lvl3;
        xirq_lvl_t lvl_spi;
        xirq_lvl_t lvl_wake;
        xirq_lvl_t lvl_bod;
        xirq_grant_t grant;
    } xirq_state_t;

endpackage

// file: xirq_ctrl.sv
// External request pins, trigger types, flags, enables and priority levels
//
// Functional notes
// R01 - Priority-low register: brown-out bit 2, wake timer bit 1, SPI bit 0.
// R02 - Priority-high register: brown-out bit 2, wake timer bit 1, SPI bit 0.
// R03 - Each of those sources gets level from its high and low bits.
// R04 - Per-input type bit: 0 low level, 1 falling edge.
// R05 - Flags 0/1 in timer control bits 1/3, flags 2/3 at 1/5.
// R06 - Edge mode: sample once per machine cycle, high then low sets flag.
// R07 - Edge flag holds until software clears it or service starts.
// R08 - Core acknowledge on service entry clears the request flag; the code clears it only in edge mode, level-mode flags follow the pin.
// R09 - Level mode: flag is the inverse of the pin level.
// R10 - Requester holds each pin level at least one machine cycle.
// R11 - Input 3 enabled by bit 6, input 2 by bit 2.
// R12 - Inputs 2/3 low bits at 3/7, high bits from outside bits 6/7.
// R13 - All four registers reset to zero.
// R14 - Level code 00 lowest up to 11 highest.
// R15 - Preempt only with strictly higher level; top level never preempted.
// R16 - Equal levels resolved by fixed order, input 0 first, brown-out last.
// R17 - Level-mode requester holds pin low until serviced, then releases.
// R18 - Pins pass a two-stage synchroniser before machine-cycle sampling.
// R19 - Hardware edge set beats a same-cycle software clear.
//
// Strobed register access was left to the implementer.
`timescale 1ns/1ps
`include "xirq_cfg.svh"

module xirq_ctrl #(
    parameter int MC_CLKS = `XIRQ_MC_CLKS_DEF
) (
    input wire logic clk,
    input wire logic sys_rst,
    input xirq_pkg::xirq_bus_t reg_bus,
    output logic [7:0] reg_rdata,
    input wire logic [3:0] irq_pin_n,
    input wire logic [3:0] svc_ack,
    input wire logic [1:0] ext01_en,
    input wire logic [3:0] ext01_prio,
    input wire logic [1:0] ext23_prio_hi,
    input wire logic [2:0] src_req,
    input wire logic active_valid,
    input xirq_pkg::xirq_lvl_t active_lvl,
    output logic [3:0] req_flag,
    output logic [3:0] req_pend,
    output xirq_pkg::xirq_lvl_t lvl_req2,
    output xirq_pkg::xirq_lvl_t lvl_req3,
    output xirq_pkg::xirq_lvl_t lvl_spi,
    output xirq_pkg::xirq_lvl_t lvl_wake,
    output xirq_pkg::xirq_lvl_t lvl_bod,
    output xirq_pkg::xirq_grant_t grant
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    xirq_pkg::xirq_state_t st;
    xirq_pkg::xirq_state_t next_st;

    localparam logic [7:0] MC_LAST = 8'(MC_CLKS - 1);

    // ----------------------------------------------------------------
    // Next-state logic
    // ----------------------------------------------------------------
    always_comb begin
        logic tick;
        logic [3:0] fall;
        logic [3:0] sw_clr;
        logic [3:0] sw_set;
        logic [7:0] wd;
        logic [`XIRQ_NUM_SRC-1:0] req;
        xirq_pkg::xirq_lvl_t lvl [`XIRQ_NUM_SRC];
        logic found;
        logic [2:0] best_idx;
        xirq_pkg::xirq_lvl_t best_lvl;
        tick = 1'b0;
        fall = 4'h0;
        sw_clr = 4'h0;
        sw_set = 4'h0;
        wd = reg_bus.wdata;
        req = '0;
        found = 1'b0;
        best_idx = 3'h0;
        best_lvl = 2'h0;
        for (int k = 0; k < `XIRQ_NUM_SRC; k++) begin
            lvl[k] = 2'h0;
        end
        next_st = st;

        // Synchroniser, first stage read only by the second [R18]
        next_st.sync1 = ~irq_pin_n;
        next_st.sync2 = st.sync1;

        // Machine-cycle sampler; relies on pins holding a level one cycle [R06] [R10]
        if (st.mc_cnt == MC_LAST) begin
            next_st.mc_cnt = 8'h00;
            tick = 1'b1;
        end else begin
            next_st.mc_cnt = st.mc_cnt + 8'h01;
        end
        if (tick) begin
            // samp holds the pin level (1 = high); high then low is a fall [R06]
            fall = st.samp & st.sync2;
            next_st.samp = ~st.sync2;
        end

        // Register writes; timer run/overflow bits belong elsewhere
        if (reg_bus.we) begin
            case (reg_bus.addr)
                `XIRQ_ADDR_TIMER_CTRL: begin
                    next_st.trig[0] = wd[`XIRQ_TC_TRIG0]; // [R04]
                    next_st.trig[1] = wd[`XIRQ_TC_TRIG1]; // [R04]
                    sw_clr[0] = ~wd[`XIRQ_TC_FLAG0]; // [R05]
                    sw_clr[1] = ~wd[`XIRQ_TC_FLAG1]; // [R05]
                    sw_set[0] = wd[`XIRQ_TC_FLAG0];
                    sw_set[1] = wd[`XIRQ_TC_FLAG1];
                end
                `XIRQ_ADDR_EXTRA_CTRL: begin
                    next_st.trig[2] = wd[`XIRQ_XC_TRIG2]; // [R04]
                    next_st.trig[3] = wd[`XIRQ_XC_TRIG3]; // [R04]
                    sw_clr[2] = ~wd[`XIRQ_XC_FLAG2]; // [R05]
                    sw_clr[3] = ~wd[`XIRQ_XC_FLAG3]; // [R05]
                    sw_set[2] = wd[`XIRQ_XC_FLAG2];
                    sw_set[3] = wd[`XIRQ_XC_FLAG3];
                    next_st.en23[0] = wd[`XIRQ_XC_EN2]; // [R11]
                    next_st.en23[1] = wd[`XIRQ_XC_EN3]; // [R11]
                    next_st.plo23[0] = wd[`XIRQ_XC_PLO2]; // [R12]
                    next_st.plo23[1] = wd[`XIRQ_XC_PLO3]; // [R12]
                end
                `XIRQ_ADDR_PRIO_HIGH: begin
                    next_st.ep_hi = wd[2:0]; // [R02]
                end
                `XIRQ_ADDR_PRIO_LOW: begin
                    next_st.ep_lo = wd[2:0]; // [R01]
                end
                default: begin
                end
            endcase
        end

        // Flags: edge mode sticky, level mode follows the pin
        for (int i = 0; i < 4; i++) begin
            if (st.trig[i]) begin
                if (fall[i]) begin
                    // Set wins over a same-cycle clear or acknowledge [R19]
                    next_st.flag[i] = 1'b1; // [R06]
                end else if (sw_clr[i] || svc_ack[i]) begin
                    next_st.flag[i] = 1'b0; // [R07] [R08]
                end else if (sw_set[i]) begin
                    // Software may raise a request of its own
                    next_st.flag[i] = 1'b1;
                end
            end else begin
                // Stays set while the requester holds the pin low [R09] [R17]
                next_st.flag[i] = st.sync2[i];
            end
        end

        // Register reads; reserved bits return zero
        next_st.rdata = `XIRQ_RST_BYTE;
        if (reg_bus.re) begin
            case (reg_bus.addr)
                `XIRQ_ADDR_TIMER_CTRL: begin
                    next_st.rdata[`XIRQ_TC_TRIG0] = st.trig[0];
                    next_st.rdata[`XIRQ_TC_FLAG0] = st.flag[0];
                    next_st.rdata[`XIRQ_TC_TRIG1] = st.trig[1];
                    next_st.rdata[`XIRQ_TC_FLAG1] = st.flag[1];
                end
                `XIRQ_ADDR_EXTRA_CTRL: begin
                    next_st.rdata[`XIRQ_XC_TRIG2] = st.trig[2];
                    next_st.rdata[`XIRQ_XC_FLAG2] = st.flag[2];
                    next_st.rdata[`XIRQ_XC_EN2] = st.en23[0];
                    next_st.rdata[`XIRQ_XC_PLO2] = st.plo23[0];
                    next_st.rdata[`XIRQ_XC_TRIG3] = st.trig[3];
                    next_st.rdata[`XIRQ_XC_FLAG3] = st.flag[3];
                    next_st.rdata[`XIRQ_XC_EN3] = st.en23[1];
                    next_st.rdata[`XIRQ_XC_PLO3] = st.plo23[1];
                end
                `XIRQ_ADDR_PRIO_HIGH: begin
                    next_st.rdata[2:0] = st.ep_hi; // [R02]
                end
                `XIRQ_ADDR_PRIO_LOW: begin
                    next_st.rdata[2:0] = st.ep_lo; // [R01]
                end
                default: begin
                end
            endcase
        end

        // ----------------------------------------------------------------
        // Levels: high bit over low bit, 00 lowest to 11 highest
        // ----------------------------------------------------------------
        next_st.lvl2 = {ext23_prio_hi[0], st.plo23[0]}; // [R12] [R14]
        next_st.lvl3 = {ext23_prio_hi[1], st.plo23[1]}; // [R12] [R14]
        next_st.lvl_spi = {st.ep_hi[`XIRQ_EP_SPI], st.ep_lo[`XIRQ_EP_SPI]}; // [R03]
        next_st.lvl_wake = {st.ep_hi[`XIRQ_EP_WAKE], st.ep_lo[`XIRQ_EP_WAKE]}; // [R03]
        next_st.lvl_bod = {st.ep_hi[`XIRQ_EP_BOD], st.ep_lo[`XIRQ_EP_BOD]}; // [R03]

        // Inputs 2 and 3 gated by their own enables here [R11]
        next_st.pend[1:0] = st.flag[1:0];
        next_st.pend[2] = st.flag[2] & st.en23[0]; // [R11]
        next_st.pend[3] = st.flag[3] & st.en23[1]; // [R11]

        // ----------------------------------------------------------------
        // Arbitration one cycle behind the flags; levels registered except inputs 0/1, taken from ext01_prio
        // ----------------------------------------------------------------
        req = {src_req[2], src_req[1], src_req[0], st.pend[3], st.pend[2],
               st.pend[1] & ext01_en[1], st.pend[0] & ext01_en[0]};
        lvl[0] = ext01_prio[1:0];
        lvl[1] = ext01_prio[3:2];
        lvl[2] = st.lvl2;
        lvl[3] = st.lvl3;
        lvl[4] = st.lvl_spi;
        lvl[5] = st.lvl_wake;
        lvl[6] = st.lvl_bod;
        // Walk from last to first so that ties fall to the earlier source [R16]
        for (int j = `XIRQ_NUM_SRC - 1; j >= 0; j--) begin
            if (req[j] && (!found || lvl[j] >= best_lvl)) begin
                found = 1'b1;
                best_idx = 3'(j);
                best_lvl = lvl[j];
            end
        end
        // Strictly higher only, so level 3 is never preempted [R15]
        next_st.grant.valid = found && (!active_valid || best_lvl > active_lvl);
        next_st.grant.idx = best_idx;
        next_st.grant.lvl = best_lvl;
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st <= '0;
            // Idle pins read high, so release of reset fakes no edge
            // Synchroniser stages hold the inverted pin, so a high pin is zero here
            st.sync1 <= ~`XIRQ_RST_PIN; // [R18]
            st.sync2 <= ~`XIRQ_RST_PIN; // [R18]
            st.samp <= `XIRQ_RST_PIN;
            st.trig <= 4'h0; // [R13]
            st.en23 <= 2'h0; // [R13]
            st.ep_hi <= 3'h0; // [R13]
            st.ep_lo <= 3'h0; // [R13]
        end else begin
            st <= next_st;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign reg_rdata = st.rdata;
    assign req_flag = st.flag;
    assign req_pend = st.pend;
    assign lvl_req2 = st.lvl2;
    assign lvl_req3 = st.lvl3;
    assign lvl_spi = st.lvl_spi;
    assign lvl_wake = st.lvl_wake;
    assign lvl_bod = st.lvl_bod;
    assign grant = st.grant;

endmodule

// file: xirq_ctrl_checker.sv
// Port-level assertions for the external request block
`timescale 1ns/1ps
`include "xirq_cfg.svh"

module xirq_ctrl_checker (
    input wire logic clk,
    input wire logic sys_rst,
    input xirq_pkg::xirq_bus_t reg_bus,
    input wire logic [7:0] reg_rdata,
    input wire logic [3:0] irq_pin_n,
    input wire logic [3:0] svc_ack,
    input wire logic [1:0] ext01_en,
    input wire logic [3:0] ext01_prio,
    input wire logic [1:0] ext23_prio_hi,
    input wire logic [2:0] src_req,
    input wire logic active_valid,
    input xirq_pkg::xirq_lvl_t active_lvl,
    input wire logic [3:0] req_flag,
    input wire logic [3:0] req_pend,
    input xirq_pkg::xirq_lvl_t lvl_req2,
    input xirq_pkg::xirq_lvl_t lvl_req3,
    input xirq_pkg::xirq_grant_t grant
);
    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    chk_rdata_idle: assert property (!$past(reg_bus.re) |-> reg_rdata == 8'h00)
        else $error("read data not zero outside answer");
    chk_prio_resv: assert property ($past(reg_bus.re && (reg_bus.addr == `XIRQ_ADDR_PRIO_LOW
        || reg_bus.addr == `XIRQ_ADDR_PRIO_HIGH)) |-> reg_rdata[7:3] == 5'h00) else $error("reserved bits set");
    chk_pend_gate: assert property (req_pend[1:0] == $past(req_flag[1:0])
        && (req_pend[3:2] & ~$past(req_flag[3:2])) == 2'b00) else $error("pending without flag");
    chk_hi_bits: assert property ({lvl_req3[1], lvl_req2[1]} == $past(ext23_prio_hi))
        else $error("input 2/3 high priority bit wrong");
    chk_grant_above: assert property (grant.valid && $past(active_valid) |-> grant.lvl > $past(active_lvl))
        else $error("grant not above running level");
    chk_grant_cause: assert property (grant.valid |-> $past(req_pend) != 4'h0 || $past(src_req) != 3'h0)
        else $error("grant without request");
    chk_tie_order: assert property (grant.valid && grant.idx == 3'h1 && $past(req_pend[0] && ext01_en[0])
        |-> $past(ext01_prio[1:0]) < grant.lvl) else $error("input 1 beat input 0");
    chk_grant_lvl: assert property (grant.valid && grant.idx == 3'h0 |-> grant.lvl == $past(ext01_prio[1:0]))
        else $error("grant level wrong");
    // Mode change by a write may drop a flag one cycle late, hence two write depths
    chk_flag_hold: assert property ($fell(req_flag[0]) |-> $past(svc_ack[0]) || $past(reg_bus.we)
        || $past(reg_bus.we, 2) || $past(irq_pin_n[0], 3)) else $error("flag 0 dropped");

    cov_preempt: cover property (grant.valid && active_valid);
    cov_flag_set: cover property ($rose(req_flag[0]));
    cov_ack_clear: cover property ($fell(req_flag[0]) && $past(svc_ack[0]));
endmodule

// file: xirq_pin_model.sv
// Requesters on the four active-low request pins
`timescale 1ns/1ps

module xirq_pin_model #(
    parameter int HOLD = 3
) (
    input wire logic clk,
    input wire logic [3:0] pull_low,
    output logic [3:0] irq_pin_n
);
    // ------------------------------------------------------------
    // Pin drive
    // ------------------------------------------------------------
    int age [4] = '{0, 0, 0, 0};

    initial begin
        irq_pin_n = 4'hf;
    end

    // A change of request waits until the old level lasted a machine cycle
    always @(posedge clk) begin
        for (int i = 0; i < 4; i++) begin
            age[i] <= age[i] + 1;
            if (age[i] >= HOLD && irq_pin_n[i] == pull_low[i]) begin
                irq_pin_n[i] <= ~pull_low[i];
                age[i] <= 0;
            end
        end
    end
endmodule

// file: test_ext_irq_and_priority_cfg.sv
// Self-checking bench for the external request block
`timescale 1ns/1ps
`include "xirq_cfg.svh"

module test_ext_irq_and_priority_cfg;
    // ------------------------------------------------------------
    // Bench
    // ------------------------------------------------------------
    localparam int MC = 3;
    localparam logic [7:0] TC = `XIRQ_ADDR_TIMER_CTRL;
    localparam logic [7:0] XC = `XIRQ_ADDR_EXTRA_CTRL;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    xirq_pkg::xirq_bus_t reg_bus = '0;
    logic [7:0] reg_rdata, d;
    logic [3:0] irq_pin_n, req_flag, req_pend;
    logic [3:0] svc_ack = '0, pull_low = '0, ext01_prio = '0;
    logic [1:0] ext01_en = '0, ext23_prio_hi = '0;
    logic [2:0] src_req = '0;
    logic active_valid = 1'b0, re_d = 1'b0;
    xirq_pkg::xirq_lvl_t active_lvl = '0, lvl_req2, lvl_req3, lvl_spi, lvl_wake, lvl_bod;
    xirq_pkg::xirq_grant_t grant;
    logic [7:0] exp_q [$];
    logic [7:0] addrs [5] = '{TC, `XIRQ_ADDR_PRIO_HIGH, `XIRQ_ADDR_PRIO_LOW, XC, 8'h90};
    int n_errors = 0, check_count = 0;

    initial begin
        forever #2.5 clk = ~clk;
    end

    xirq_ctrl #(.MC_CLKS(MC)) dut (.clk, .sys_rst, .reg_bus, .reg_rdata, .irq_pin_n, .svc_ack, .ext01_en,
        .ext01_prio, .ext23_prio_hi, .src_req, .active_valid, .active_lvl, .req_flag, .req_pend, .lvl_req2,
        .lvl_req3, .lvl_spi, .lvl_wake, .lvl_bod, .grant);
    xirq_pin_model #(.HOLD(MC)) peer (.clk, .pull_low, .irq_pin_n);

    task automatic check(input string what, input logic [7:0] e, input logic [7:0] seen);
        check_count++;
        if (seen !== e) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", what, e, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        reg_bus <= '{addr: a, wdata: v, we: 1'b1, re: 1'b0};
        @(posedge clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        reg_bus <= '{addr: a, wdata: 8'h00, we: 1'b0, re: 1'b1};
        @(posedge clk);
    endtask
    // Both strobes drop here; wr and rd each also drop the other strobe, so none is assigned twice in one step
    task automatic idle(input int n);
        reg_bus <= '0;
        repeat (n) @(posedge clk);
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        re_d <= reg_bus.re;
        if (re_d) begin
            check("reg_rdata", exp_q.pop_front(), reg_rdata);
        end
    end

    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        test_done();
    end

    initial begin
        void'($urandom(91786));
        repeat (16) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        foreach (addrs[i]) rd(addrs[i], 8'h00);
        idle(2);
        $display("test reset done");
        repeat (8) begin
            d = 8'($urandom());
            ext23_prio_hi <= d[4:3];
            wr(`XIRQ_ADDR_PRIO_HIGH, d);
            wr(`XIRQ_ADDR_PRIO_LOW, ~d);
            wr(XC, d & 8'hdd);
            wr(TC, d & 8'hf5);
            rd(`XIRQ_ADDR_PRIO_HIGH, d & 8'h07);
            rd(`XIRQ_ADDR_PRIO_LOW, ~d & 8'h07);
            rd(XC, d & 8'hdd);
            rd(TC, d & 8'h05);
            idle(1);
            #1;
            check("lvl_bod", {6'h00, d[2], ~d[2]}, {6'h00, lvl_bod});
            check("lvl_spi", {6'h00, d[0], ~d[0]}, {6'h00, lvl_spi});
            check("lvl_req3", {6'h00, d[4], d[7]}, {6'h00, lvl_req3});
            check("lvl_req2", {6'h00, d[3], d[3]}, {6'h00, lvl_req2});
            check("lvl_wake", {6'h00, d[1], ~d[1]}, {6'h00, lvl_wake});
            // Back onto the rising edge before driving again
            @(posedge clk);
        end
        $display("test fields done");
        wr(XC, 8'h00);
        wr(TC, 8'h05);
        pull_low <= 4'h1;
        idle(4 * MC);
        rd(TC, 8'h07);
        pull_low <= 4'h0;
        idle(4 * MC);
        rd(TC, 8'h07);
        svc_ack <= 4'h1;
        idle(1);
        svc_ack <= 4'h0;
        rd(TC, 8'h05);
        pull_low <= 4'h1;
        idle(4 * MC);
        wr(TC, 8'h05);
        rd(TC, 8'h05);
        pull_low <= 4'h0;
        $display("test edge done");
        wr(TC, 8'h00);
        pull_low <= 4'h2;
        idle(3 * MC);
        rd(TC, 8'h08);
        svc_ack <= 4'h2;
        idle(1);
        svc_ack <= 4'h0;
        rd(TC, 8'h08);
        pull_low <= 4'h0; // Released once serviced
        idle(3 * MC);
        rd(TC, 8'h00);
        $display("test level done");
        ext23_prio_hi <= 2'b00;
        wr(XC, 8'h44);
        pull_low <= 4'hc;
        idle(3 * MC);
        rd(XC, 8'h66);
        idle(3);
        #1;
        check("grant", 8'h28, {2'b00, grant});
        @(posedge clk);
        active_valid <= 1'b1;
        idle(3);
        #1;
        check("grant_valid", 8'h00, {7'h00, grant.valid});
        @(posedge clk);
        ext23_prio_hi <= 2'b10;
        idle(3);
        #1;
        check("grant", 8'h2e, {2'b00, grant});
        @(posedge clk);
        wr(XC, 8'h00);
        idle(3);
        #1;
        check("req_pend", 8'h00, {4'h0, req_pend});
        check("req_flag", 8'h0c, {4'h0, req_flag});
        @(posedge clk);
        $display("test grant done");
        wr(TC, 8'h05);
        repeat (200) begin
            {ext01_en, ext01_prio, src_req, active_valid, active_lvl, ext23_prio_hi, pull_low} <= 18'($urandom());
            idle(MC);
        end
        $display("test soak done");
        test_done();
    end
endmodule

bind xirq_ctrl xirq_ctrl_checker chk (.clk, .sys_rst, .reg_bus, .reg_rdata, .irq_pin_n, .svc_ack, .ext01_en,
    .ext01_prio, .ext23_prio_hi, .src_req, .active_valid, .active_lvl, .req_flag, .req_pend, .lvl_req2,
    .lvl_req3, .grant);
